// File: hdl/app_defs.vh
// register offsets, field positions, reset values and timing for the auxiliary parallel port
// assumes an includer that uses these as plain `define macros
`ifndef APP_DEFS_VH
`define APP_DEFS_VH

// byte offsets on the register bus
`define APP_OFS_STATUS      8'h00
`define APP_OFS_HWCFG0      8'h04
`define APP_OFS_HWCFG1      8'h08
`define APP_OFS_HWCFG3      8'h0C
`define APP_OFS_DOUT_SLOT0  8'h10
`define APP_OFS_DOUT_SLOT1  8'h14
`define APP_OFS_DOUT_SLOT2  8'h18
`define APP_OFS_DOUT_MAIN   8'h1C
`define APP_OFS_DIN         8'h20
`define APP_OFS_DIR         8'h24
`define APP_OFS_LATCH       8'h28
`define APP_OFS_SEL_FIRST   8'h2C
`define APP_OFS_SEL_SECOND  8'h30
`define APP_OFS_INTMASK     8'h34

// field positions
`define APP_STAT_EVT_BIT    0
`define APP_HWC0_DRIVE_BIT  1
`define APP_HWC1_MODE_HI    7
`define APP_HWC1_MODE_LO    6
`define APP_HWC3_MIXED_BIT  2
`define APP_INTERRUPT_MASK_REGISTER_EVT_BIT    0

// port modes
`define APP_MODE_NORMAL     2'h0
`define APP_MODE_STATIC     2'h1
`define APP_MODE_MUX        2'h2

// reset values
`define APP_RST_BYTE        8'h00
`define APP_RST_WORD        16'h0000

// bus responses
`define APP_RESP_OKAY       2'h0
`define APP_RESP_SLVERR     2'h2

// timing, clock at 100 MHz
`define APP_CLK_MHZ         100
`define APP_TICK_US         1000
`define APP_SLOT_US         2000
`define APP_GAP_US          125
`define APP_TICK_CYC        (`APP_TICK_US * `APP_CLK_MHZ)
`define APP_SLOT_CYC        (`APP_SLOT_US * `APP_CLK_MHZ)
`define APP_GAP_CYC         (`APP_GAP_US * `APP_CLK_MHZ)

`endif

// File: hdl/app_port.v
// auxiliary parallel port: static and multiplexed pin I/O, edge events, AXI4-Lite registers
// assumes one clock aclk at 100 MHz, synchronous active-low reset, pads resolved outside
//
// Overview of operation
// - port pins only active while memory interface runs a flash mode.
// - mode field bits 7:6 select normal, static, multiplex; 11 reserved.
// - mixed enable hands pins 8-11 to flash selects, port keeps the rest.
// - static mode: sixteen identical pins, each direction set by direction register.
// - static outputs continuously drive the matching main output register bit.
// - static inputs read live, without latching.
// - multiplex mode: pins 12-15 are one-hot strobes for four 2 ms slots.
// - a 125 us gap with no strobe separates consecutive slots.
// - slots 0,1,2 drive pins 0-11 from slot registers, strobes 15,14,13.
// - slot 3, strobe 12: direction register per pin, outputs from main register.
// - multiplex inputs captured at falling edge of strobe 12.
// - static edge detection compares present value with sample 1 ms earlier.
// - multiplex edge detection compares with capture of previous input slot.
// - two select bits per pin: off, rising, falling, both edges.
// - matched edge sets pin bit in event latch and the port event flag.
// - interrupt output follows event flag only when its mask bit allows.
// - reading the event latch clears it and the port event flag.
// - writing zero to event latch stops detection, nonzero starts it.
// - status word bit 0 is the port event flag, read only.
// - drive style bit: 0 open drain, 1 push/pull interrupt output.
`include "app_defs.vh"
`default_nettype none

module app_port #(
	parameter integer TICK_CYC = `APP_TICK_CYC,
	parameter integer SLOT_CYC = `APP_SLOT_CYC,
	parameter integer GAP_CYC  = `APP_GAP_CYC,
	parameter integer CNT_W    = 18
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        mem_flash_mode,
	input  wire [15:0] memory_address_lines_in,
	output reg  [15:0] memory_address_lines_out,
	output reg  [15:0] memory_address_lines_oe,
	output reg         flash_select_owns_pins,
	output reg         irq_n_out,
	output reg         irq_n_oe
);

	localparam [1:0] ST_SLOT = 2'b01;
	localparam [1:0] ST_GAP  = 2'b10;
	localparam [CNT_W-1:0] CNT_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [CNT_W-1:0] TICK_LAST = TICK_CYC[CNT_W-1:0] - CNT_ONE;
	localparam [CNT_W-1:0] SLOT_LAST = SLOT_CYC[CNT_W-1:0] - CNT_ONE;
	localparam [CNT_W-1:0] GAP_LAST  = GAP_CYC[CNT_W-1:0] - CNT_ONE;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
		end
	endfunction

	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr[7:2] == ofs[7:2]);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers

	reg [7:0]  hwc0_q;
	reg [7:0]  hwc1_q;
	reg [7:0]  hwc3_q;
	reg [11:0] port_output_slot0_q;
	reg [11:0] port_output_slot1_q;
	reg [11:0] port_output_slot2_q;
	reg [15:0] port_output_main_q;
	reg [15:0] dir_q;
	reg [15:0] sel1_q;
	reg [15:0] sel2_q;
	reg [15:0] interrupt_mask_register_q;
	reg [15:0] latch_q;
	reg [15:0] din_q;
	reg        flag_q;
	reg        det_en_q;

	wire [1:0] mode = hwc1_q[`APP_HWC1_MODE_HI:`APP_HWC1_MODE_LO];
	wire       mixed = hwc3_q[`APP_HWC3_MIXED_BIT];
	wire       port_static = mem_flash_mode && (mode == `APP_MODE_STATIC);
	wire       port_mux    = mem_flash_mode && (mode == `APP_MODE_MUX);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchroniser: change counts when stages two and three agree

	reg [15:0] sync1_q;
	reg [15:0] sync2_q;
	reg [15:0] sync3_q;
	reg [15:0] pin_q;
	integer i;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= `APP_RST_WORD;
			sync2_q <= `APP_RST_WORD;
			sync3_q <= `APP_RST_WORD;
			pin_q   <= `APP_RST_WORD;
		end else begin
			sync1_q <= memory_address_lines_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (i = 0; i < 16; i = i + 1) begin
				if (sync2_q[i] == sync3_q[i]) begin
					pin_q[i] <= sync3_q[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timing: 1 ms tick and multiplex slot sequencer

	reg [CNT_W-1:0] tick_cnt_q;
	reg             tick_q;
	reg [CNT_W-1:0] seq_cnt_q;
	reg [1:0]       seq_st_q;
	reg [1:0]       slot_q;
	reg             cap_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_q <= {CNT_W{1'b0}};
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= {CNT_W{1'b0}};
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + CNT_ONE;
			tick_q     <= 1'b0;
		end
	end

	// sequencer restarts from slot 0 whenever multiplex mode is left
	always @(posedge aclk) begin
		if (!aresetn || !port_mux) begin
			seq_cnt_q <= {CNT_W{1'b0}};
			seq_st_q  <= ST_SLOT;
			slot_q    <= 2'd0;
			cap_q     <= 1'b0;
		end else begin
			cap_q <= 1'b0;
			case (seq_st_q)
				ST_SLOT: begin
					if (seq_cnt_q == SLOT_LAST) begin
						seq_cnt_q <= {CNT_W{1'b0}};
						seq_st_q  <= ST_GAP;
						cap_q     <= (slot_q == 2'd3);
					end else begin
						seq_cnt_q <= seq_cnt_q + CNT_ONE;
					end
				end
				ST_GAP: begin
					if (seq_cnt_q == GAP_LAST) begin
						seq_cnt_q <= {CNT_W{1'b0}};
						seq_st_q  <= ST_SLOT;
						slot_q    <= slot_q + 2'd1;
					end else begin
						seq_cnt_q <= seq_cnt_q + CNT_ONE;
					end
				end
				default: begin
					seq_cnt_q <= {CNT_W{1'b0}};
					seq_st_q  <= ST_SLOT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive

	reg [15:0] pad_out_d;
	reg [15:0] pad_oe_d;

	always @* begin
		pad_out_d = `APP_RST_WORD;
		pad_oe_d  = `APP_RST_WORD;
		if (port_static) begin
			pad_out_d = port_output_main_q;
			pad_oe_d  = dir_q;
		end else if (port_mux) begin
			pad_oe_d[15:12] = 4'hF;
			if (seq_st_q == ST_SLOT) begin
				case (slot_q)
					2'd0: begin
						pad_out_d = {4'h8, port_output_slot0_q};
						pad_oe_d[11:0] = 12'hFFF;
					end
					2'd1: begin
						pad_out_d = {4'h4, port_output_slot1_q};
						pad_oe_d[11:0] = 12'hFFF;
					end
					2'd2: begin
						pad_out_d = {4'h2, port_output_slot2_q};
						pad_oe_d[11:0] = 12'hFFF;
					end
					default: begin
						pad_out_d = {4'h1, port_output_main_q[11:0]};
						pad_oe_d[11:0] = dir_q[11:0];
					end
				endcase
			end
		end
		// flash selects own pins 8-11, so the port lets go of them
		if (mixed) begin
			pad_oe_d[11:8]  = 4'h0;
			pad_out_d[11:8] = 4'h0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			memory_address_lines_out <= `APP_RST_WORD;
			memory_address_lines_oe  <= `APP_RST_WORD;
			flash_select_owns_pins   <= 1'b0;
		end else begin
			memory_address_lines_out <= pad_out_d;
			memory_address_lines_oe  <= pad_oe_d;
			flash_select_owns_pins   <= mixed && mem_flash_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// input sampling and edge detection

	reg  [15:0] prev_q;
	reg  [15:0] cur_v;
	reg  [15:0] prv_v;
	reg         cmp_v;
	wire [15:0] is_input = ~dir_q & (port_mux ? 16'h0FFF : 16'hFFFF);
	wire [15:0] evt_vec;

	always @* begin
		cur_v = pin_q;
		prv_v = prev_q;
		cmp_v = 1'b0;
		if (port_static) begin
			cmp_v = tick_q;
		end else if (port_mux) begin
			cur_v = {4'h0, (pin_q[11:0] & is_input[11:0]) | (din_q[11:0] & ~is_input[11:0])};
			prv_v = din_q;
			cmp_v = cap_q;
		end
	end

	// second select bit alone catches rising, first alone falling
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_edge
			assign evt_vec[g] = det_en_q && cmp_v && is_input[g]
				&& ((sel2_q[g] && !prv_v[g] && cur_v[g])
				|| (sel1_q[g] && prv_v[g] && !cur_v[g]));
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= `APP_RST_WORD;
			din_q  <= `APP_RST_WORD;
		end else begin
			if (port_static) begin
				din_q <= pin_q;
				if (tick_q) begin
					prev_q <= pin_q;
				end
			end else if (cap_q) begin
				din_q <= cur_v;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	wire ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	wire [7:0] wa = s_axi_awaddr;
	wire [7:0] ra = s_axi_araddr;
	wire latch_rd = ar_take && hit(ra, `APP_OFS_LATCH);
	wire latch_wr = aw_take && hit(wa, `APP_OFS_LATCH) && (s_axi_wstrb[1:0] != 2'b00);
	wire [15:0] latch_wval = merge16(latch_q, s_axi_wdata, s_axi_wstrb);
	wire [15:0] slot0_wval = merge16({4'h0, port_output_slot0_q}, s_axi_wdata, s_axi_wstrb);
	wire [15:0] slot1_wval = merge16({4'h0, port_output_slot1_q}, s_axi_wdata, s_axi_wstrb);
	wire [15:0] slot2_wval = merge16({4'h0, port_output_slot2_q}, s_axi_wdata, s_axi_wstrb);
	reg  wr_ok;
	reg  [15:0] rd_v;
	reg  rd_ok;

	always @* begin
		wr_ok = 1'b1;
		if (hit(wa, `APP_OFS_HWCFG0)) begin
			wr_ok = 1'b1;
		end else if (hit(wa, `APP_OFS_HWCFG1) || hit(wa, `APP_OFS_HWCFG3)) begin
			wr_ok = 1'b1;
		end else if (wa[7:2] >= `APP_OFS_DOUT_SLOT0 >> 2 && wa[7:2] <= `APP_OFS_INTMASK >> 2) begin
			wr_ok = !hit(wa, `APP_OFS_DIN);
		end else begin
			wr_ok = 1'b0;
		end
	end

	always @* begin
		rd_v  = `APP_RST_WORD;
		rd_ok = 1'b1;
		if (hit(ra, `APP_OFS_STATUS)) begin
			rd_v[`APP_STAT_EVT_BIT] = flag_q;
		end else if (hit(ra, `APP_OFS_HWCFG0)) begin
			rd_v = {8'h00, hwc0_q};
		end else if (hit(ra, `APP_OFS_HWCFG1)) begin
			rd_v = {8'h00, hwc1_q};
		end else if (hit(ra, `APP_OFS_HWCFG3)) begin
			rd_v = {8'h00, hwc3_q};
		end else if (hit(ra, `APP_OFS_DOUT_SLOT0)) begin
			rd_v = {4'h0, port_output_slot0_q};
		end else if (hit(ra, `APP_OFS_DOUT_SLOT1)) begin
			rd_v = {4'h0, port_output_slot1_q};
		end else if (hit(ra, `APP_OFS_DOUT_SLOT2)) begin
			rd_v = {4'h0, port_output_slot2_q};
		end else if (hit(ra, `APP_OFS_DOUT_MAIN)) begin
			rd_v = port_output_main_q;
		end else if (hit(ra, `APP_OFS_DIN)) begin
			rd_v = din_q;
		end else if (hit(ra, `APP_OFS_DIR)) begin
			rd_v = dir_q;
		end else if (hit(ra, `APP_OFS_LATCH)) begin
			rd_v = latch_q;
		end else if (hit(ra, `APP_OFS_SEL_FIRST)) begin
			rd_v = sel1_q;
		end else if (hit(ra, `APP_OFS_SEL_SECOND)) begin
			rd_v = sel2_q;
		end else if (hit(ra, `APP_OFS_INTMASK)) begin
			rd_v = interrupt_mask_register_q;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `APP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `APP_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
		end else begin
			s_axi_awready <= aw_take;
			s_axi_wready  <= aw_take;
			if (aw_take) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `APP_RESP_OKAY : `APP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {16'h0000, rd_v};
				s_axi_rresp  <= rd_ok ? `APP_RESP_OKAY : `APP_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes and event state

	always @(posedge aclk) begin
		if (!aresetn) begin
			hwc0_q  <= `APP_RST_BYTE;
			hwc1_q  <= `APP_RST_BYTE;
			hwc3_q  <= `APP_RST_BYTE;
			port_output_slot0_q <= 12'h000;
			port_output_slot1_q <= 12'h000;
			port_output_slot2_q <= 12'h000;
			port_output_main_q <= `APP_RST_WORD;
			dir_q   <= `APP_RST_WORD;
			sel1_q  <= `APP_RST_WORD;
			sel2_q  <= `APP_RST_WORD;
			interrupt_mask_register_q  <= `APP_RST_WORD;
		end else if (aw_take && s_axi_wstrb[0] && hit(wa, `APP_OFS_HWCFG0)) begin
			hwc0_q <= {1'b0, s_axi_wdata[6:0]}; // top bit always reads as zero
		end else if (aw_take && s_axi_wstrb[0] && hit(wa, `APP_OFS_HWCFG1)) begin
			hwc1_q <= s_axi_wdata[7:0];
		end else if (aw_take && s_axi_wstrb[0] && hit(wa, `APP_OFS_HWCFG3)) begin
			hwc3_q <= s_axi_wdata[7:0] & 8'h1C;
		end else if (aw_take && hit(wa, `APP_OFS_DOUT_SLOT0)) begin
			port_output_slot0_q <= slot0_wval[11:0];
		end else if (aw_take && hit(wa, `APP_OFS_DOUT_SLOT1)) begin
			port_output_slot1_q <= slot1_wval[11:0];
		end else if (aw_take && hit(wa, `APP_OFS_DOUT_SLOT2)) begin
			port_output_slot2_q <= slot2_wval[11:0];
		end else if (aw_take && hit(wa, `APP_OFS_DOUT_MAIN)) begin
			port_output_main_q <= merge16(port_output_main_q, s_axi_wdata, s_axi_wstrb);
		end else if (aw_take && hit(wa, `APP_OFS_DIR)) begin
			dir_q <= merge16(dir_q, s_axi_wdata, s_axi_wstrb);
		end else if (aw_take && hit(wa, `APP_OFS_SEL_FIRST)) begin
			sel1_q <= merge16(sel1_q, s_axi_wdata, s_axi_wstrb);
		end else if (aw_take && hit(wa, `APP_OFS_SEL_SECOND)) begin
			sel2_q <= merge16(sel2_q, s_axi_wdata, s_axi_wstrb);
		end else if (aw_take && hit(wa, `APP_OFS_INTMASK)) begin
			interrupt_mask_register_q <= merge16(interrupt_mask_register_q, s_axi_wdata, s_axi_wstrb);
		end
	end

	// a read clears, but an edge in the same cycle survives it
	always @(posedge aclk) begin
		if (!aresetn) begin
			latch_q  <= `APP_RST_WORD;
			flag_q   <= 1'b0;
			det_en_q <= 1'b0;
		end else begin
			if (latch_wr) begin
				det_en_q <= (latch_wval != `APP_RST_WORD);
			end
			latch_q <= (latch_rd ? `APP_RST_WORD : latch_q) | evt_vec;
			flag_q  <= (flag_q && !latch_rd) || (evt_vec != `APP_RST_WORD);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt pin, active low

	wire irq_act = flag_q && interrupt_mask_register_q[`APP_INTERRUPT_MASK_REGISTER_EVT_BIT];

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_n_out <= 1'b1;
			irq_n_oe  <= 1'b0;
		end else if (hwc0_q[`APP_HWC0_DRIVE_BIT]) begin
			irq_n_out <= !irq_act;
			irq_n_oe  <= 1'b1;
		end else begin
			irq_n_out <= 1'b0;
			irq_n_oe  <= irq_act;
		end
	end

endmodule // app_port

`default_nettype wire

// File: tb/app_keypad.sv
// key matrix and display stand-in on the spare address pins
// assumes the bench sets key levels; a driven pin reads back its own drive
`default_nettype none

module app_keypad (
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] key_lvl,
	output logic      [15:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	// released pins show the contacts, which the bench holds steady long enough
	assign pin_lvl = (pin_out & pin_oe) | (key_lvl & ~pin_oe);
endmodule // app_keypad
`default_nettype wire

// File: tb/app_port_sva.sv
// checker for the auxiliary port: strobe timing, pin release, interrupt drive, bus answers
// assumes bind onto app_port; port mode and drive style are tracked by watching bus writes
`default_nettype none
`include "app_defs.vh"

module app_port_sva #(
	parameter integer SLOT_CYC = 40
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arready,
	input wire logic        mem_flash_mode,
	input wire logic [15:0] memory_address_lines_out,
	input wire logic [15:0] memory_address_lines_oe,
	input wire logic        flash_select_owns_pins,
	input wire logic        irq_n_out,
	input wire logic        irq_n_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0]  mode_q;
	logic        style_q;
	logic [2:0]  st_q;
	logic [3:0]  prev_q;
	logic [15:0] len_q;
	wire  [3:0]  strb = memory_address_lines_out[15:12] & memory_address_lines_oe[15:12];
	wire         cfg1 = s_axi_awready && s_axi_awaddr == `APP_OFS_HWCFG1;
	wire         cfg0 = s_axi_awready && s_axi_awaddr == `APP_OFS_HWCFG0;
	// settle gate: pads lag a mode or style change by a few cycles
	wire         mux  = mode_q == `APP_MODE_MUX && mem_flash_mode && st_q == 3'h7;
	////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_q  <= `APP_MODE_NORMAL;
			style_q <= 1'b0;
			st_q    <= 3'h0;
			prev_q  <= 4'h0;
			len_q   <= 16'h0000;
		end else begin
			if (cfg1)
				mode_q <= s_axi_wdata[7:6];
			if (cfg0)
				style_q <= s_axi_wdata[1];
			st_q   <= (cfg0 || cfg1 || !mem_flash_mode) ? 3'h0 : st_q + {2'h0, st_q != 3'h7};
			prev_q <= !mux ? 4'h0 : (|strb ? strb : prev_q);
			len_q  <= |strb ? len_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	property p_onehot; mux |-> $onehot0(strb); endproperty
	a_onehot: assert property (p_onehot) else $error("strobes overlap");
	property p_slot_len; mux && $fell(|strb) |-> len_q == SLOT_CYC; endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot length wrong");
	property p_gap; mux && $fell(|strb) |-> (strb == 4'h0)[*5] ##[1:2] (|strb); endproperty
	a_gap: assert property (p_gap) else $error("gap between slots wrong");
	property p_order;
		mux && $rose(|strb) && prev_q != 4'h0 |-> strb == (prev_q == 4'h1 ? 4'h8 : prev_q >> 1);
	endproperty
	a_order: assert property (p_order) else $error("slot order wrong");
	property p_flash_off;
		!mem_flash_mode [*3] |-> memory_address_lines_oe == 16'h0000 && !flash_select_owns_pins;
	endproperty
	a_flash_off: assert property (p_flash_off) else $error("pins driven outside flash mode");
	property p_mixed; flash_select_owns_pins [*3] |-> memory_address_lines_oe[11:8] == 4'h0; endproperty
	a_mixed: assert property (p_mixed) else $error("select pins still driven");
	property p_status_ro;
		s_axi_awready && s_axi_awaddr == `APP_OFS_STATUS |-> s_axi_bresp == `APP_RESP_SLVERR;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write accepted");
	property p_latch_clr;
		s_axi_arready && s_axi_araddr == `APP_OFS_LATCH |-> ##[1:4] !(irq_n_oe && !irq_n_out);
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("irq stays after latch read");
	property p_open_drain; !style_q && st_q == 3'h7 |-> !(irq_n_oe && irq_n_out); endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drives high");
	property p_push_pull; style_q && st_q == 3'h7 |-> irq_n_oe; endproperty
	a_push_pull: assert property (p_push_pull) else $error("push pull not driving");
endmodule // app_port_sva

bind app_port app_port_sva #(.SLOT_CYC(SLOT_CYC)) u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_bresp(s_axi_bresp),
	.s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready), .mem_flash_mode(mem_flash_mode),
	.memory_address_lines_out(memory_address_lines_out),
	.memory_address_lines_oe(memory_address_lines_oe),
	.flash_select_owns_pins(flash_select_owns_pins), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe)
);
`default_nettype wire

// File: tb/app_port_tb.sv
// self-checking bench for the auxiliary port, driven over its register bus
// assumes app_port, the keypad stand-in and the bound checker are compiled first
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end

module app_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, mem_flash_mode, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, v;
	logic [3:0]  wstrb;
	logic [15:0] key;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire         awready, wready, bvalid, arready, rvalid, owns, irq_out, irq_oe;
	wire  [15:0] pad_in, pad_out, pad_oe;
	logic [11:0] exp_s [4] = '{12'h111, 12'h222, 12'h333, 12'h040};
	int          error_cnt = 0, samples_checked = 0, cyc = 0;

	app_port #(.TICK_CYC(20), .SLOT_CYC(40), .GAP_CYC(5)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.mem_flash_mode(mem_flash_mode), .memory_address_lines_in(pad_in),
		.memory_address_lines_out(pad_out), .memory_address_lines_oe(pad_oe),
		.flash_select_owns_pins(owns), .irq_n_out(irq_out), .irq_n_oe(irq_oe)
	);
	app_keypad u_keys (.pin_out(pad_out), .pin_oe(pad_oe), .key_lvl(key), .pin_lvl(pad_in));
	////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// each channel is released at the edge that samples its own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0,
			input logic [3:0] s = 4'hF);
		logic [1:0] seen;
		seen = 2'b00;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			seen = seen | {awready, wready};
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		`CHK(seen, 2'b11)
		`CHK(bresp, r)
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
		logic seen;
		seen = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			seen = seen | arready;
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		`CHK(seen, 1'b1)
		`CHK(rresp, r)
		rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a, 2'h0, v);
		`CHK(v, e)
	endtask
	// bounded wait for a strobe, then let the pads settle inside the slot
	task automatic wait_pin(input int b);
		for (int n = 0; n < 400 && !(pad_out[b] && pad_oe[b]); n++)
			@(posedge aclk);
		repeat (3) @(posedge aclk);
	endtask
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, mem_flash_mode, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, key} = 64'h0;
		wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 4; a <= 8'h34; a += 4)
			if (a != 8'h20) rdc(a[7:0], 32'h0);
		rd(8'h3C, 2'h2, v);
		`CHK(v, 32'h0)
		wr(8'h00, 32'h1, 2'h2);
		wr(8'h20, 32'h1, 2'h2);
		rdc(8'h00, 32'h0);
		wr(8'h1C, 32'h1234, 2'h0, 4'h1);
		rdc(8'h1C, 32'h34);
		$display("test access done");
		mem_flash_mode <= 1'b1;
		key <= 16'h5A3C;
		wr(8'h08, 32'h40);
		wr(8'h24, 32'h00FF);
		wr(8'h1C, 32'h00A5);
		repeat (8) @(posedge aclk);
		`CHK(pad_oe, 16'h00FF)
		`CHK(pad_out & pad_oe, 16'h00A5)
		rdc(8'h20, 32'h5AA5);
		key <= 16'hC300;
		repeat (8) @(posedge aclk);
		rdc(8'h20, 32'hC3A5);
		wr(8'h0C, 32'h04);
		wr(8'h24, 32'hFFFF);
		repeat (8) @(posedge aclk);
		`CHK(owns, 1'b1)
		`CHK(pad_oe, 16'hF0FF)
		wr(8'h0C, 32'h0);
		mem_flash_mode <= 1'b0;
		repeat (8) @(posedge aclk);
		`CHK(pad_oe, 16'h0)
		mem_flash_mode <= 1'b1;
		for (int m = 0; m < 4; m += 3) begin
			wr(8'h08, m << 6);
			repeat (8) @(posedge aclk);
			`CHK(pad_oe, 16'h0)
		end
		$display("test static done");
		wr(8'h08, 32'h40);
		wr(8'h24, 32'h0);
		wr(8'h2C, 32'h6);
		wr(8'h30, 32'h5);
		wr(8'h34, 32'h1);
		key <= 16'h0;
		wr(8'h28, 32'hFFFF);
		repeat (80) @(posedge aclk);
		rd(8'h28, 2'h0, v);
		key <= 16'h000F;
		repeat (80) @(posedge aclk);
		`CHK({irq_oe, irq_out}, 2'b10)
		rdc(8'h00, 32'h1);
		rdc(8'h28, 32'h5);
		rdc(8'h00, 32'h0);
		`CHK(irq_oe, 1'b0)
		key <= 16'h0;
		repeat (80) @(posedge aclk);
		rdc(8'h28, 32'h6);
		wr(8'h04, 32'h02);
		wr(8'h34, 32'h0);
		key <= 16'h000F;
		repeat (80) @(posedge aclk);
		`CHK({irq_oe, irq_out}, 2'b11)
		rdc(8'h00, 32'h1);
		rdc(8'h28, 32'h5);
		wr(8'h28, 32'h0);
		key <= 16'h0;
		repeat (80) @(posedge aclk);
		rdc(8'h28, 32'h0);
		rdc(8'h00, 32'h0);
		$display("test edges done");
		wr(8'h10, 32'h111);
		wr(8'h14, 32'h222);
		wr(8'h18, 32'h333);
		wr(8'h1C, 32'h0F44);
		wr(8'h24, 32'h0F0);
		wr(8'h34, 32'h1);
		wr(8'h08, 32'h80);
		wr(8'h28, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wait_pin(15 - i);
			`CHK(pad_out[15:12] & pad_oe[15:12], 4'h8 >> i)
			`CHK(pad_oe[11:0], i == 3 ? 12'h0F0 : 12'hFFF)
			`CHK(pad_out[11:0] & pad_oe[11:0], exp_s[i])
		end
		repeat (400) @(posedge aclk);
		rd(8'h28, 2'h0, v);
		key <= 16'h000F;
		repeat (400) @(posedge aclk);
		rdc(8'h28, 32'h5);
		rd(8'h20, 2'h0, v);
		`CHK(v[11:0] & 12'hF0F, 12'h00F)
		$display("test multiplex done");
		summarize();
	end
endmodule // app_port_tb
`default_nettype wire
